// ### rtl/cssi_pkg.sv
package cssi_pkg;

  // Fault persistence before falling back to the other input.
  localparam int FALLBACK_TIME_MS = 2500;
  localparam int CLK_PERIOD_NS = 10;
  // Divide first, because the product in nanoseconds would overflow a 32-bit int.
  localparam int FALLBACK_CYCLES = FALLBACK_TIME_MS * (1000000 / CLK_PERIOD_NS);

  // Third summary register field positions.
  localparam int SUM_CTRL_BIT = 0;
  localparam int SUM_AUX_BIT = 1;
  localparam int SUM_INT_BIT = 2;

  // Controller live status field positions.
  localparam int CTL_WDG_BIT = 0;
  localparam int CTL_WALL_BIT = 1;
  localparam int CTL_USB_BIT = 2;
  localparam int CTL_BAT_BIT = 3;
  localparam int CTL_TEMP_BIT = 4;
  localparam int CTL_OSC_BIT = 5;
  localparam int CTL_EOC_BIT = 6;
  localparam int CTL_BOV_BIT = 7;
  localparam int CTL_SOV_BIT = 8;
  localparam int CTL_GATED_BIT = 9;
  localparam int CTL_WIDTH = 10;

  localparam logic [CTL_WIDTH-1:0] CTL_RESET = 10'h000;
  localparam logic [2:0] SUM_RESET = 3'h0;

  typedef enum logic {CSSI_SRC_USB, CSSI_SRC_WALL} cssi_src_t;

endpackage

// ### rtl/cssi_sync.sv
`timescale 1ns/1ps
module cssi_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_stage1 = din;
    next_dout = stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= next_stage1;
      dout <= next_dout;
    end
  end

endmodule

// ### rtl/cssi_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE_01: USB attach only above minimum input threshold.
// RULE_02: Port sense high means charging port; polarity selectable.
// RULE_03: Suspend bit gates charging, clearing resumes.
// RULE_04: Auxiliary charger enabled by driving low.
// RULE_05: Auxiliary charger pulls status low when operating.
// RULE_06: During power-on reset, pick the only present input.
// RULE_07: Both present, no port, no adapter: wall.
// RULE_08: Both present, port or adapter: USB.
// RULE_09: Fault lasting 2.5 s falls back once, never returns.
// RULE_10: Single charger fault ends only at watchdog.
// RULE_11: Host reads all three summary registers.
// RULE_12: Third summary holds controller, auxiliary, internal bits.
// RULE_13: Controller status is live, unlatched.
// RULE_14: Auxiliary status bit follows input level.
// RULE_15: Internal charger status latches, clears on read.
// RULE_16: Temperature out of window gates, raises interrupt.
// RULE_17: Watchdog expiry raises fault; host restarts charging.
// RULE_18: Wall and USB crossings interrupt both directions.
// RULE_19: Battery presence change interrupt when enabled.
// RULE_20: Temperature gating and flag when enabled.
// RULE_21: Charge complete and overvoltages only with power path.
// RULE_22: Oscillator failure raises controller interrupt.
// RULE_23: Every source maskable from the interrupt line.
// RULE_24: Interrupt low while any unmasked summary pending.
module cssi_top
  import cssi_pkg::*;
#(
  parameter int FALLBACK_COUNT = FALLBACK_CYCLES,
  parameter int INT_WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Pin inputs from analog comparators and other parties
  input wire logic power_on_reset_n,
  input wire logic usb_above_min,
  input wire logic wall_input,
  input wire logic charge_port_sense_n,
  input wire logic adapter_resistance_a,
  input wire logic adapter_resistance_b,
  input wire logic adapter_resistance_c,
  input wire logic aux_charger_status_n,
  input wire logic charger_fault,
  input wire logic watchdog_expired,
  input wire logic battery_present,
  input wire logic battery_temp_out_of_window,
  input wire logic oscillator_failure,
  input wire logic charge_complete,
  input wire logic battery_overvoltage,
  input wire logic system_overvoltage,
  input wire logic [INT_WIDTH-1:0] internal_charger_event,
  // One-time-programmable configuration
  input wire logic port_sense_polarity,
  input wire logic temp_gating_enable,
  input wire logic presence_detect_enable,
  input wire logic power_path_config,
  // Host control
  input wire logic charge_suspend,
  input wire logic hw_control,
  input wire logic charge_enable,
  input wire logic [CTL_WIDTH-1:0] controller_mask,
  input wire logic aux_mask,
  input wire logic [INT_WIDTH-1:0] internal_mask,
  input wire logic internal_status_read,
  // Outputs to chargers
  output logic aux_charger_enable_n,
  output logic usb_charge_enable,
  output logic charge_gated,
  output logic selected_wall,
  // Status and interrupt
  output logic [CTL_WIDTH-1:0] controller_live_status,
  output logic aux_charger_live,
  output logic [INT_WIDTH-1:0] internal_charger_latched_status,
  output logic [2:0] irq_summary_third,
  output logic irq_n
);

  localparam int NPIN = 16;
  localparam int CW = $clog2(FALLBACK_COUNT + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(FALLBACK_COUNT);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  logic [INT_WIDTH-1:0] ev_s;

  // The auxiliary status is inverted before the synchroniser, so that its cleared stages read as idle.
  // Otherwise the first cycles after reset would report a running auxiliary charger and a false interrupt.
  assign pin_raw = {power_on_reset_n, usb_above_min, wall_input, charge_port_sense_n,
                    adapter_resistance_a, adapter_resistance_b, adapter_resistance_c,
                    ~aux_charger_status_n, charger_fault, watchdog_expired, battery_present,
                    battery_temp_out_of_window, oscillator_failure, charge_complete,
                    battery_overvoltage, system_overvoltage};

  cssi_sync #(.WIDTH(NPIN)) u_sync_pins (
    .clk(clk),
    .srst(srst),
    .din(pin_raw),
    .dout(pin_s)
  );

  cssi_sync #(.WIDTH(INT_WIDTH)) u_sync_ev (
    .clk(clk),
    .srst(srst),
    .din(internal_charger_event),
    .dout(ev_s)
  );

  logic por_n_s;
  logic usb_s;
  logic wall_s;
  logic sense_n_s;
  logic rid_s;
  logic aux_stat_n_s;
  logic fault_s;
  logic wdg_s;
  logic bat_s;
  logic temp_s;
  logic osc_s;
  logic eoc_s;
  logic bov_s;
  logic sov_s;

  always_comb begin
    por_n_s = pin_s[15];
    usb_s = pin_s[14];
    wall_s = pin_s[13];
    sense_n_s = pin_s[12];
    rid_s = pin_s[11] | pin_s[10] | pin_s[9];
    aux_stat_n_s = ~pin_s[8];
    fault_s = pin_s[7];
    wdg_s = pin_s[6];
    bat_s = pin_s[5];
    temp_s = pin_s[4];
    osc_s = pin_s[3];
    eoc_s = pin_s[2];
    bov_s = pin_s[1];
    sov_s = pin_s[0];
  end

  // Source selection state.
  cssi_src_t src, next_src;
  logic fell_back, next_fell_back;
  logic [CW-1:0] fault_cnt, next_fault_cnt;
  logic terminated, next_terminated;
  logic usb_prev, next_usb_prev;
  logic wall_prev, next_wall_prev;
  logic bat_prev, next_bat_prev;
  logic temp_prev, next_temp_prev;
  logic [INT_WIDTH-1:0] int_stat, next_int_stat;
  logic usb_attached, port_found, both, gated;

  always_comb begin
    // RULE_01: attach above threshold.
    usb_attached = usb_s;
    // RULE_02: selectable port polarity.
    port_found = sense_n_s ^ port_sense_polarity;
    both = usb_attached & wall_s;
    next_src = src;
    next_fell_back = fell_back;
    next_fault_cnt = fault_cnt;
    next_terminated = terminated;
    if (!por_n_s) begin
      next_fell_back = 1'b0;
      next_fault_cnt = '0;
      next_terminated = 1'b0;
      // RULE_06: priority during power-on reset.
      if (usb_attached && !wall_s) begin
        next_src = CSSI_SRC_USB;
      end else if (wall_s && !usb_attached) begin
        next_src = CSSI_SRC_WALL;
      end else if (both) begin
        // RULE_07: wall by default.
        // RULE_08: USB when port or adapter.
        next_src = (port_found || rid_s) ? CSSI_SRC_USB : CSSI_SRC_WALL;
      end
    end
    // The count saturates, so a fault held far beyond the window cannot wrap.
    if (hw_control && fault_s) begin
      if (fault_cnt != CNT_MAX) begin
        next_fault_cnt = CW'(fault_cnt + 1'b1);
      end
    end else begin
      next_fault_cnt = '0;
    end
    // RULE_09: single fallback, no return.
    if (both && !fell_back && hw_control && fault_cnt == CNT_MAX) begin
      next_src = (src == CSSI_SRC_USB) ? CSSI_SRC_WALL : CSSI_SRC_USB;
      next_fell_back = 1'b1;
      next_fault_cnt = '0;
    end
    // RULE_10: lone charger ends at watchdog.
    if (!both && fault_s && wdg_s) begin
      next_terminated = 1'b1;
    end
    if (!fault_s && !wdg_s) begin
      next_terminated = 1'b0;
    end
    next_usb_prev = usb_attached;
    next_wall_prev = wall_s;
    next_bat_prev = bat_s;
    next_temp_prev = temp_s;
    // RULE_15: latch, set wins over read clear.
    next_int_stat = (internal_status_read ? '0 : int_stat) | ev_s;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      src <= CSSI_SRC_USB;
      fell_back <= 1'b0;
      fault_cnt <= '0;
      terminated <= 1'b0;
      usb_prev <= 1'b0;
      wall_prev <= 1'b0;
      bat_prev <= 1'b0;
      temp_prev <= 1'b0;
      int_stat <= '0;
    end else begin
      src <= next_src;
      fell_back <= next_fell_back;
      fault_cnt <= next_fault_cnt;
      terminated <= next_terminated;
      usb_prev <= next_usb_prev;
      wall_prev <= next_wall_prev;
      bat_prev <= next_bat_prev;
      temp_prev <= next_temp_prev;
      int_stat <= next_int_stat;
    end
  end

  // Output registers.
  logic [CTL_WIDTH-1:0] ctl, next_ctl;
  logic next_aux_en_n;
  logic next_usb_en;
  logic next_gated;
  logic next_sel_wall;
  logic next_aux_live;
  logic next_irq_n;
  logic [2:0] next_sum;
  logic [CTL_WIDTH-1:0] ctl_masked;

  always_comb begin
    // RULE_13: live status, unlatched.
    next_ctl = CTL_RESET;
    // RULE_17: watchdog fault source.
    next_ctl[CTL_WDG_BIT] = wdg_s;
    // RULE_18: crossings in either direction.
    next_ctl[CTL_WALL_BIT] = wall_s ^ wall_prev;
    next_ctl[CTL_USB_BIT] = usb_attached ^ usb_prev;
    // RULE_19: presence change when enabled.
    next_ctl[CTL_BAT_BIT] = presence_detect_enable & (bat_s ^ bat_prev);
    // RULE_20: temperature crossing when enabled.
    next_ctl[CTL_TEMP_BIT] = temp_gating_enable & (temp_s ^ temp_prev);
    // RULE_22: oscillator failure.
    next_ctl[CTL_OSC_BIT] = osc_s;
    // RULE_21: power path only.
    next_ctl[CTL_EOC_BIT] = power_path_config & eoc_s;
    next_ctl[CTL_BOV_BIT] = power_path_config & bov_s;
    next_ctl[CTL_SOV_BIT] = power_path_config & sov_s;
    // RULE_16: out-of-window gates charging.
    gated = (temp_gating_enable & temp_s) | charge_suspend | terminated | wdg_s;
    next_ctl[CTL_GATED_BIT] = temp_gating_enable & temp_s;
    next_sel_wall = (src == CSSI_SRC_WALL);
    // RULE_03: suspend gates without touching parameters.
    next_gated = gated;
    // RULE_04: active-low auxiliary enable.
    next_aux_en_n = !(charge_enable && next_sel_wall && wall_s && !gated);
    next_usb_en = charge_enable && !next_sel_wall && usb_attached && !gated;
    // RULE_14: live auxiliary status level.
    // The auxiliary part pulls its line low while it runs.
    next_aux_live = !aux_stat_n_s;
    // RULE_23: per-source masks.
    ctl_masked = ctl & ~controller_mask;
    // RULE_12: three charging summary bits.
    next_sum = SUM_RESET;
    next_sum[SUM_CTRL_BIT] = |ctl_masked;
    next_sum[SUM_AUX_BIT] = aux_charger_live & ~aux_mask;
    next_sum[SUM_INT_BIT] = |(int_stat & ~internal_mask);
    // RULE_24: line low while any summary pending.
    next_irq_n = ~|next_sum;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctl <= CTL_RESET;
      aux_charger_enable_n <= 1'b1;
      usb_charge_enable <= 1'b0;
      charge_gated <= 1'b0;
      selected_wall <= 1'b0;
      aux_charger_live <= 1'b0;
      irq_summary_third <= SUM_RESET;
      irq_n <= 1'b1;
    end else begin
      ctl <= next_ctl;
      aux_charger_enable_n <= next_aux_en_n;
      usb_charge_enable <= next_usb_en;
      charge_gated <= next_gated;
      selected_wall <= next_sel_wall;
      aux_charger_live <= next_aux_live;
      irq_summary_third <= next_sum;
      irq_n <= next_irq_n;
    end
  end

  assign controller_live_status = ctl;
  assign internal_charger_latched_status = int_stat;

endmodule

// ### sim/cssi_top_properties.sv
`timescale 1ns/1ps
module cssi_top_properties
  import cssi_pkg::*;
#(
  parameter int INT_WIDTH = 8
) (
  // Watched ports
  input wire logic clk,
  input wire logic srst,
  input wire logic wall_input,
  input wire logic aux_charger_status_n,
  input wire logic battery_temp_out_of_window,
  input wire logic oscillator_failure,
  input wire logic temp_gating_enable,
  input wire logic presence_detect_enable,
  input wire logic power_path_config,
  input wire logic [CTL_WIDTH-1:0] controller_mask,
  input wire logic aux_mask,
  input wire logic [INT_WIDTH-1:0] internal_mask,
  input wire logic internal_status_read,
  input wire logic aux_charger_live,
  input wire logic charge_gated,
  input wire logic [CTL_WIDTH-1:0] controller_live_status,
  input wire logic [INT_WIDTH-1:0] internal_charger_latched_status,
  input wire logic [2:0] irq_summary_third,
  input wire logic irq_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_OSC_LIVE: assert property (!$past(srst, 4) |->
    controller_live_status[CTL_OSC_BIT] == $past(oscillator_failure, 3)) else $error("osc bit wrong");
  AST_AUX_LIVE: assert property ($changed(aux_charger_status_n) |-> ##3 $changed(aux_charger_live))
    else $error("aux live wrong");
  AST_TEMP_GATE: assert property ((temp_gating_enable && battery_temp_out_of_window)[*4] |-> charge_gated)
    else $error("temp not gated");
  AST_IRQ_LINE: assert property (irq_n == !(|irq_summary_third))
    else $error("irq line wrong");
  AST_ALL_MASKED: assert property ((&controller_mask && aux_mask && &internal_mask)[*6] |-> irq_n)
    else $error("masked irq seen");
  AST_POWER_PATH: assert property (!$past(power_path_config) |->
    controller_live_status[CTL_SOV_BIT:CTL_EOC_BIT] == 3'h0) else $error("power path bits wrong");
  AST_PRESENCE: assert property (!$past(presence_detect_enable) |-> !controller_live_status[CTL_BAT_BIT])
    else $error("presence bit wrong");
  AST_WALL_CROSS: assert property ($changed(wall_input) |->
    ##3 controller_live_status[CTL_WALL_BIT] ##1 !controller_live_status[CTL_WALL_BIT]) else $error("wall cross");
  AST_LATCH_HOLD: assert property (|($past(internal_charger_latched_status) &
    ~internal_charger_latched_status) |-> $past(internal_status_read)) else $error("latch lost");
endmodule

// ### sim/cssi_aux_model.sv
`timescale 1ns/1ps
module cssi_aux_model #(
  parameter int START_DELAY = 3
) (
  // Clock
  input wire logic clk,
  // Charger pins
  input wire logic aux_charger_enable_n,
  output logic aux_charger_status_n = 1'b1
);
  int cnt = 0;
  always @(posedge clk) begin
    cnt <= aux_charger_enable_n ? 0 : cnt + 1;
    aux_charger_status_n <= !(!aux_charger_enable_n && cnt >= START_DELAY);
  end
endmodule

// ### sim/tb_charger_source_select_and_irq.sv
`timescale 1ns/1ps
module tb_charger_source_select_and_irq;
  import cssi_pkg::*;
  localparam int INT_WIDTH = 8;
  logic clk = 0, srst = 1, power_on_reset_n = 0, usb_above_min = 0, wall_input = 0, charge_port_sense_n = 0;
  logic adapter_resistance_a = 0, adapter_resistance_b = 0, adapter_resistance_c = 0, aux_charger_status_n;
  logic charger_fault = 0, watchdog_expired = 0, battery_present = 0, battery_temp_out_of_window = 0;
  logic oscillator_failure = 0, charge_complete = 0, battery_overvoltage = 0, system_overvoltage = 0;
  logic port_sense_polarity = 0, temp_gating_enable = 0, presence_detect_enable = 0, power_path_config = 0;
  logic charge_suspend = 0, hw_control = 0, charge_enable = 0, aux_mask = 0, internal_status_read = 0;
  logic [INT_WIDTH-1:0] internal_charger_event = '0, internal_mask = '0, internal_charger_latched_status;
  logic [CTL_WIDTH-1:0] controller_mask = '0, controller_live_status;
  logic aux_charger_enable_n, usb_charge_enable, charge_gated, selected_wall, aux_charger_live, irq_n;
  logic [2:0] irq_summary_third;
  int error_cnt = 0, checked = 0, cyc = 0;
  // Row: polarity, usb, wall, sense, adapter a, b, c, expected wall choice.
  logic [7:0] rows [9] = '{8'h40, 8'h21, 8'h61, 8'h70, 8'h68, 8'h64, 8'h62, 8'hF1, 8'hE0};

  cssi_top #(.FALLBACK_COUNT(20), .INT_WIDTH(INT_WIDTH)) cssi_top_inst (
    .clk(clk), .srst(srst), .power_on_reset_n(power_on_reset_n), .usb_above_min(usb_above_min),
    .wall_input(wall_input), .charge_port_sense_n(charge_port_sense_n),
    .adapter_resistance_a(adapter_resistance_a), .adapter_resistance_b(adapter_resistance_b),
    .adapter_resistance_c(adapter_resistance_c), .aux_charger_status_n(aux_charger_status_n),
    .charger_fault(charger_fault), .watchdog_expired(watchdog_expired), .battery_present(battery_present),
    .battery_temp_out_of_window(battery_temp_out_of_window), .oscillator_failure(oscillator_failure),
    .charge_complete(charge_complete), .battery_overvoltage(battery_overvoltage),
    .system_overvoltage(system_overvoltage), .internal_charger_event(internal_charger_event),
    .port_sense_polarity(port_sense_polarity), .temp_gating_enable(temp_gating_enable),
    .presence_detect_enable(presence_detect_enable), .power_path_config(power_path_config),
    .charge_suspend(charge_suspend), .hw_control(hw_control), .charge_enable(charge_enable),
    .controller_mask(controller_mask), .aux_mask(aux_mask), .internal_mask(internal_mask),
    .internal_status_read(internal_status_read), .aux_charger_enable_n(aux_charger_enable_n),
    .usb_charge_enable(usb_charge_enable), .charge_gated(charge_gated), .selected_wall(selected_wall),
    .controller_live_status(controller_live_status), .aux_charger_live(aux_charger_live),
    .internal_charger_latched_status(internal_charger_latched_status),
    .irq_summary_third(irq_summary_third), .irq_n(irq_n)
  );
  cssi_aux_model cssi_aux_model_inst (
    .clk(clk),
    .aux_charger_enable_n(aux_charger_enable_n),
    .aux_charger_status_n(aux_charger_status_n)
  );

  initial forever #5 clk = ~clk;

  task automatic chk(string n, logic [9:0] e, logic [9:0] s);
    checked++;
    if (e !== s) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic end_of_test;
    if (error_cnt == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic wait_n(int n);
    repeat (n) @(negedge clk);
  endtask

  // A hang is cut short well past the expected run length.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test;
    end
  end

  initial begin
    wait_n(5);
    srst = 0;
    charge_enable = 1;
    for (int i = 0; i < 9; i++) begin
      {port_sense_polarity, usb_above_min, wall_input, charge_port_sense_n, adapter_resistance_a,
       adapter_resistance_b, adapter_resistance_c} = rows[i][7:1];
      wait_n(8);
      chk("selected_wall", rows[i][0], selected_wall);
    end
    port_sense_polarity = 0;
    wait_n(8);
    chk("selected_wall", 1, selected_wall);
    power_on_reset_n = 1;
    hw_control = 1;
    charger_fault = 1;
    wait_n(8);
    chk("selected_wall", 1, selected_wall);
    chk("aux_charger_enable_n", 0, aux_charger_enable_n);
    chk("aux_charger_live", 1, aux_charger_live);
    chk("sum_aux", 1, irq_summary_third[SUM_AUX_BIT]);
    wait_n(30);
    chk("selected_wall", 0, selected_wall);
    chk("usb_charge_enable", 1, usb_charge_enable);
    chk("aux_charger_enable_n", 1, aux_charger_enable_n);
    charger_fault = 0;
    wait_n(5);
    charger_fault = 1;
    wait_n(30);
    chk("selected_wall", 0, selected_wall);
    charger_fault = 0;
    temp_gating_enable = 1;
    battery_temp_out_of_window = 1;
    wait_n(6);
    chk("gated_bit", 1, controller_live_status[CTL_GATED_BIT]);
    chk("sum_ctrl", 1, irq_summary_third[SUM_CTRL_BIT]);
    chk("irq_n", 0, irq_n);
    controller_mask = '1;
    wait_n(6);
    chk("irq_n", 1, irq_n);
    controller_mask = '0;
    battery_temp_out_of_window = 0;
    wait_n(6);
    chk("charge_gated", 0, charge_gated);
    chk("irq_n", 1, irq_n);
    charge_suspend = 1;
    wait_n(6);
    chk("charge_gated", 1, charge_gated);
    charge_suspend = 0;
    wait_n(6);
    chk("charge_gated", 0, charge_gated);
    internal_charger_event = 8'h08;
    wait_n(1);
    internal_charger_event = 8'h00;
    wait_n(10);
    chk("latched", 10'h008, internal_charger_latched_status);
    chk("sum_int", 1, irq_summary_third[SUM_INT_BIT]);
    internal_status_read = 1;
    wait_n(1);
    internal_status_read = 0;
    wait_n(6);
    chk("latched", 10'h000, internal_charger_latched_status);
    chk("irq_n", 1, irq_n);
    presence_detect_enable = 1;
    battery_present = 1;
    oscillator_failure = 1;
    power_path_config = 1;
    charge_complete = 1;
    wait_n(6);
    chk("osc_bit", 1, controller_live_status[CTL_OSC_BIT]);
    chk("eoc_bit", 1, controller_live_status[CTL_EOC_BIT]);
    oscillator_failure = 0;
    charge_complete = 0;
    watchdog_expired = 1;
    wait_n(6);
    chk("wdg_bit", 1, controller_live_status[CTL_WDG_BIT]);
    chk("irq_n", 0, irq_n);
    {controller_mask, aux_mask, internal_mask} = '1;
    wait_n(8);
    chk("irq_n", 1, irq_n);
    wall_input = 0;
    charger_fault = 1;
    wait_n(6);
    watchdog_expired = 0;
    wait_n(6);
    chk("charge_gated", 1, charge_gated);
    charger_fault = 0;
    wait_n(6);
    chk("charge_gated", 0, charge_gated);
    srst = 1;
    wait_n(5);
    chk("aux_charger_enable_n", 1, aux_charger_enable_n);
    chk("irq_n", 1, irq_n);
    srst = 0;
    wait_n(6);
    chk("usb_charge_enable", 1, usb_charge_enable);
    end_of_test;
  end
endmodule

bind cssi_top cssi_top_properties #(.INT_WIDTH(INT_WIDTH)) cssi_top_properties_inst (
  .clk(clk), .srst(srst), .wall_input(wall_input), .aux_charger_status_n(aux_charger_status_n),
  .battery_temp_out_of_window(battery_temp_out_of_window), .oscillator_failure(oscillator_failure),
  .temp_gating_enable(temp_gating_enable), .presence_detect_enable(presence_detect_enable),
  .power_path_config(power_path_config), .controller_mask(controller_mask), .aux_mask(aux_mask),
  .internal_mask(internal_mask), .internal_status_read(internal_status_read),
  .aux_charger_live(aux_charger_live), .charge_gated(charge_gated),
  .controller_live_status(controller_live_status),
  .internal_charger_latched_status(internal_charger_latched_status),
  .irq_summary_third(irq_summary_third), .irq_n(irq_n)
);
